// File: verilog/sram_host_pkg.sv
package sram_host_pkg;

  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_NS = 8;

  // Least intervals in ns
  localparam int ADDR_SETUP_END_NS = 35;
  localparam int STROBE_PULSE_NS = 35;
  localparam int DATA_SETUP_NS = 20;
  localparam int ACCESS_NS = 45;
  localparam int TURN_OFF_NS = 25;

  // Cycle counts rounded up
  localparam int STROBE_CYC =
    (STROBE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TURN_OFF_CYC =
    (TURN_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;

  typedef struct packed {
    logic rd_wr_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } req_t;

  typedef struct packed {
    logic select_low_active_n;
    logic chip_select_high_active;
    logic strobe_n;
    logic gate_n;
  } ctl_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_SETUP = 5'h02,
    ST_STROBE = 5'h04,
    ST_READ = 5'h08,
    ST_RECOV = 5'h10
  } state_t;

endpackage

// File: verilog/sram_host.sv
module sram_host
  import sram_host_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Request side
  input wire logic i_req_valid,
  input wire req_t i_req,
  output logic o_req_ready,
  output logic o_rd_valid,
  output logic [DATA_W-1:0] o_rd_data,
  // Memory pins
  output ctl_t o_ctl,
  output logic [ADDR_W-1:0] o_word_address_lines,
  input wire logic [DATA_W-1:0] i_shared_data_lines,
  output logic [DATA_W-1:0] o_shared_data_lines,
  output logic o_shared_data_lines_oe
);

  state_t state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  ctl_t next_ctl;
  logic [ADDR_W-1:0] next_addr;
  logic [DATA_W-1:0] next_dout, next_rd_data;
  logic next_oe, next_ready, next_rd_valid;
  logic [DATA_W-1:0] din_meta, din_sync;
  logic take;

  // ----------------------------------------
  // Data input synchroniser
  // ----------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      din_meta <= '0;
      din_sync <= '0;
    end else begin
      din_meta <= i_shared_data_lines;
      din_sync <= din_meta;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // Request accepted on this edge
  assign take = i_req_valid && o_req_ready;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_ctl = o_ctl;
    unique case (state)
      ST_IDLE: begin
        if (take) begin
          next_ctl.gate_n = ~i_req.rd_wr_n;
          next_state = i_req.rd_wr_n ? ST_READ : ST_SETUP;
          next_ctl.select_low_active_n = 1'b0;
          next_ctl.chip_select_high_active = 1'b1;
          next_cnt = CNT_W'(ACCESS_CYC);
        end
      end
      ST_SETUP: begin
        next_ctl.strobe_n = 1'b0;
        next_cnt = CNT_W'(STROBE_CYC);
        next_state = ST_STROBE;
      end
      ST_STROBE: begin
        next_cnt = cnt - CNT_W'(1);
        if (cnt == CNT_W'(1)) begin
          next_ctl.strobe_n = 1'b1;
          next_cnt = CNT_W'(1);
          next_state = ST_RECOV;
        end
      end
      ST_READ: begin
        next_cnt = cnt - CNT_W'(1);
        if (cnt == CNT_W'(1)) begin
          next_ctl.gate_n = 1'b1;
          next_ctl.select_low_active_n = 1'b1;
          next_ctl.chip_select_high_active = 1'b0;
          next_cnt = CNT_W'(TURN_OFF_CYC);
          next_state = ST_RECOV;
        end
      end
      ST_RECOV: begin
        next_ctl.select_low_active_n = 1'b1;
        next_ctl.chip_select_high_active = 1'b0;
        next_cnt = cnt - CNT_W'(1);
        if (cnt <= CNT_W'(1)) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_ctl = '{1'b1, 1'b0, 1'b1, 1'b1};
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= ST_IDLE;
      cnt <= '0;
      o_ctl <= '{1'b1, 1'b0, 1'b1, 1'b1};
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      o_ctl <= next_ctl;
    end
  end

  // ----------------------------------------
  // Address and write data pins
  // ----------------------------------------
  always_comb begin
    next_addr = o_word_address_lines;
    next_dout = o_shared_data_lines;
    next_oe = o_shared_data_lines_oe;
    unique case (state)
      ST_IDLE: begin
        if (take) begin
          next_addr = i_req.addr;
          next_dout = i_req.wdata;
          next_oe = 1'b0;
        end
      end
      ST_SETUP: begin
        next_oe = 1'b1;
      end
      ST_STROBE, ST_READ: begin
        next_oe = o_shared_data_lines_oe;
      end
      ST_RECOV: begin
        next_oe = 1'b0;
      end
      default: begin
        next_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_word_address_lines <= '0;
      o_shared_data_lines <= '0;
      o_shared_data_lines_oe <= 1'b0;
    end else begin
      o_word_address_lines <= next_addr;
      o_shared_data_lines <= next_dout;
      o_shared_data_lines_oe <= next_oe;
    end
  end

  // ----------------------------------------
  // Request side response
  // ----------------------------------------
  always_comb begin
    next_ready = 1'b0;
    next_rd_valid = 1'b0;
    next_rd_data = o_rd_data;
    unique case (state)
      ST_IDLE: begin
        next_ready = !take;
      end
      ST_READ: begin
        // Synchronised bus value at end of access
        if (cnt == CNT_W'(1)) begin
          next_rd_data = din_sync;
          next_rd_valid = 1'b1;
        end
      end
      ST_RECOV: begin
        next_ready = (cnt <= CNT_W'(1));
      end
      default: begin
        next_ready = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_req_ready <= 1'b0;
      o_rd_valid <= 1'b0;
      o_rd_data <= '0;
    end else begin
      o_req_ready <= next_ready;
      o_rd_valid <= next_rd_valid;
      o_rd_data <= next_rd_data;
    end
  end

endmodule // sram_host

// File: verification/sram_host_asserts.sv
module sram_host_checker
  import sram_host_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire ctl_t o_ctl,
  input wire logic [ADDR_W-1:0] o_word_address_lines,
  input wire logic [DATA_W-1:0] o_shared_data_lines,
  input wire logic o_shared_data_lines_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // ----
  // Pin checks
  // ----
  sequence s_low4;
    !o_ctl.strobe_n [*4] ##1 o_ctl.strobe_n;
  endsequence
  chk_gate_read: assert property (!o_ctl.gate_n |-> o_ctl.strobe_n)
    else $error("gate low in write");
  chk_addr_setup: assert property ($fell(o_ctl.strobe_n) |->
    $stable(o_word_address_lines)) else $error("addr setup");
  chk_addr_hold: assert property ($changed(o_word_address_lines) |->
    $past(o_ctl.strobe_n)) else $error("addr hold");
  chk_data_setup: assert property ($rose(o_ctl.strobe_n) |->
    $past(o_shared_data_lines_oe, 3) && $stable(o_shared_data_lines))
    else $error("data setup");
  chk_data_desel: assert property ($rose(o_ctl.select_low_active_n) |->
    $stable(o_shared_data_lines)) else $error("data hold");
  chk_no_contend: assert property (o_shared_data_lines_oe |->
    o_ctl.gate_n) else $error("contention");
  chk_strobe_width: assert property ($fell(o_ctl.strobe_n) |=>
    s_low4) else $error("strobe width");
endmodule // sram_host_checker

bind sram_host sram_host_checker i_chk (.i_clk(i_clk), .i_rst(i_rst),
  .o_ctl(o_ctl), .o_word_address_lines(o_word_address_lines),
  .o_shared_data_lines(o_shared_data_lines),
  .o_shared_data_lines_oe(o_shared_data_lines_oe));

// File: verification/sram_mem_model.sv
module sram_mem_model
  import sram_host_pkg::*;
(
  input wire ctl_t i_ctl,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_din,
  output logic [DATA_W-1:0] o_dout,
  output logic o_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [DATA_W-1:0] last = 8'h00;
  logic sel;
  assign sel = !i_ctl.select_low_active_n && i_ctl.chip_select_high_active;
  assign o_oe = sel && !i_ctl.gate_n && i_ctl.strobe_n;
  always @* if (sel && !i_ctl.strobe_n)
    mem[i_addr] = i_din;
  always @* if (o_oe)
    last = mem[i_addr];
  assign o_dout = o_oe ? mem[i_addr] : ~last;
endmodule // sram_mem_model

// File: verification/tb_sram_host.sv
module tb_sram_host
  import sram_host_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {req_t r; logic [DATA_W-1:0] rd;} row_t;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic valid = 1'b0;
  req_t req = '0;
  logic ready, rd_valid, host_oe;
  logic [DATA_W-1:0] rd_data, host_d, mem_d, bus;
  logic [ADDR_W-1:0] addr;
  ctl_t ctl;
  int err_count = 0;
  int n_compared = 0;
  row_t rows [6] = '{'{'{1'b0, 13'h0000, 8'hA5}, 8'h00},
    '{'{1'b0, 13'h1FFF, 8'h5A}, 8'h00}, '{'{1'b0, 13'h0ABC, 8'h3C}, 8'h00},
    '{'{1'b1, 13'h0ABC, 8'h00}, 8'h3C}, '{'{1'b1, 13'h0000, 8'h00}, 8'hA5},
    '{'{1'b1, 13'h1FFF, 8'h00}, 8'h5A}};
  assign bus = host_oe ? host_d : mem_d;
  initial forever #4 i_clk = ~i_clk;
  sram_host i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_req_valid(valid),
    .i_req(req), .o_req_ready(ready), .o_rd_valid(rd_valid),
    .o_rd_data(rd_data), .o_ctl(ctl), .o_word_address_lines(addr),
    .i_shared_data_lines(bus), .o_shared_data_lines(host_d),
    .o_shared_data_lines_oe(host_oe));
  sram_mem_model i_mem (.i_ctl(ctl), .i_addr(addr), .i_din(bus),
    .o_dout(mem_d), .o_oe());
  task automatic cmp(string what, logic [7:0] exp, logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic run(row_t w);
    int n;
    n = 0;
    @(posedge i_clk) valid <= 1'b1;
    req <= w.r;
    do @(negedge i_clk); while (ready !== 1'b1 && ++n < 40);
    @(posedge i_clk) valid <= 1'b0;
    do @(negedge i_clk); while (w.r.rd_wr_n && rd_valid !== 1'b1 && ++n < 60);
    if (n >= 40) begin
      err_count++;
      results();
    end else if (w.r.rd_wr_n) begin
      cmp("rd_data", w.rd, rd_data);
    end
  endtask
  initial begin
    repeat (2) @(posedge i_clk);
    cmp("ctl_reset", 8'h0B, 8'(ctl));
    i_rst <= 1'b0;
    foreach (rows[i]) begin
      run(rows[i]);
      $display("row %0d done", i);
    end
    @(posedge i_clk) i_rst <= 1'b1;
    @(negedge i_clk);
    cmp("oe_midreset", 8'h00, 8'(host_oe));
    @(posedge i_clk) i_rst <= 1'b0;
    run(rows[5]);
    $display("reset test done");
    results();
  end
endmodule // tb_sram_host
